// [rtl/acs_host.sv]
// Host end: APB registers driving conversions and serial transfers
`timescale 1ns/1ps
`default_nettype none
`include "acs_map.svh"
module acs_host (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // APB slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // Interrupt
   output logic o_irq,
   // Pins toward the converter
   acs_if.host lnk
);
   import acs_pkg::*;

   // ******************************
   // Pin synchronisers
   // ******************************
   logic bsy_lvl, bsy_fall; // Converter busy
   logic otf_lvl, otf_fall; // Over-temperature flag
   logic dat_lvl; // Serial data from the converter
   acs_sync #(.P_INIT(1'b0)) u_bsy (
      .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_async(lnk.busy),
      .o_lvl(bsy_lvl), .o_rise(), .o_fall(bsy_fall)
   );
   acs_sync #(.P_INIT(1'b1)) u_otf (
      .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_async(lnk.over_temp_flag_n),
      .o_lvl(otf_lvl), .o_rise(), .o_fall(otf_fall)
   );
   acs_sync #(.P_INIT(1'b1)) u_dat (
      .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_async(lnk.dout_line),
      .o_lvl(dat_lvl), .o_rise(), .o_fall()
   );

   // ******************************
   // APB decode
   // ******************************
   logic setup, acc, hit;
   logic wr_ctrl, wr_txd, wr_stat, wr_mask;
   logic pd; // Keep convert start low after the pulse
   logic [15:0] txd; // Write data
   logic [`ACS_RES_W-1:0] rxd; // Last read data
   logic [`ACS_EV_W-1:0] stat, mask, ev; // Sticky events, enables
   acs_hst_t st;
   assign setup = i_psel && !i_penable;
   assign acc = i_psel && i_penable && o_pready;
   assign hit = (i_paddr == `ACS_REG_CTRL) || (i_paddr == `ACS_REG_TXD) ||
                (i_paddr == `ACS_REG_RXD) || (i_paddr == `ACS_REG_STAT) ||
                (i_paddr == `ACS_REG_MASK);
   assign wr_ctrl = acc && i_pwrite && (i_paddr == `ACS_REG_CTRL);
   assign wr_txd = acc && i_pwrite && (i_paddr == `ACS_REG_TXD);
   assign wr_stat = acc && i_pwrite && (i_paddr == `ACS_REG_STAT);
   assign wr_mask = acc && i_pwrite && (i_paddr == `ACS_REG_MASK);

   // One wait-free access phase; read data fixed during setup
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata <= 32'h0000_0000;
      end else begin
         o_pready <= setup;
         o_pslverr <= setup && !hit;
         o_prdata <= 32'h0000_0000;
         if (setup && !i_pwrite) begin
            case (i_paddr)
               `ACS_REG_CTRL: begin
                  o_prdata[`ACS_CTL_PD] <= pd;
                  o_prdata[`ACS_CTL_ENG] <= (st != H_IDLE);
                  o_prdata[`ACS_CTL_BUSY] <= bsy_lvl;
                  o_prdata[`ACS_CTL_OTF] <= otf_lvl;
               end
               `ACS_REG_TXD: o_prdata[15:0] <= txd;
               `ACS_REG_RXD: o_prdata[`ACS_RES_W-1:0] <= rxd;
               `ACS_REG_STAT: o_prdata[`ACS_EV_W-1:0] <= stat;
               `ACS_REG_MASK: o_prdata[`ACS_EV_W-1:0] <= mask;
               default: o_prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Plain control registers
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         pd <= 1'b0;
         txd <= 16'h0000;
         mask <= '0;
      end else begin
         if (wr_ctrl) begin
            pd <= i_pwdata[`ACS_CTL_PD];
         end
         if (wr_txd) begin
            txd <= i_pwdata[15:0];
         end
         if (wr_mask) begin
            mask <= i_pwdata[`ACS_EV_W-1:0];
         end
      end
   end

   // ******************************
   // Transfer engine
   // ******************************
   logic [4:0] cnt; // Half-period and pulse timer
   logic [4:0] bcnt, nbits; // Bits done, bits wanted
   logic [15:0] tx; // Outgoing shift register
   logic [`ACS_RES_W-1:0] rx; // Incoming shift register
   logic is_rd; // Current transfer reads
   logic cs_n, rd_wr, sclk, din, cst_n;
   logic tmo; // Timer expired
   assign tmo = (cnt == 5'h00);

   // Commands are ignored while the engine is busy
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         st <= H_IDLE;
         cnt <= 5'h00;
         bcnt <= 5'h00;
         nbits <= 5'h00;
         tx <= 16'h0000;
         rx <= '0;
         rxd <= '0;
         is_rd <= 1'b0;
         cs_n <= 1'b1;
         rd_wr <= 1'b0;
         sclk <= 1'b0;
         din <= 1'b0;
         cst_n <= 1'b1;
      end else begin
         if (!tmo) begin
            cnt <= cnt - 5'h01;
         end
         case (st)
            H_IDLE: begin
               if (!pd) begin
                  cst_n <= 1'b1;
               end
               if (wr_ctrl && i_pwdata[`ACS_CTL_START]) begin
                  st <= H_CONV;
                  cst_n <= 1'b0;
                  cnt <= 5'(`ACS_CST_LO_CYC - 1);
               end else if (wr_ctrl && (i_pwdata[`ACS_CTL_READ] || i_pwdata[`ACS_CTL_WRITE])) begin
                  // Select first, direction on the same edge; both lead the first rising shift clock edge by 32 cycles
                  st <= H_SEL;
                  cs_n <= 1'b0;
                  is_rd <= i_pwdata[`ACS_CTL_READ];
                  rd_wr <= i_pwdata[`ACS_CTL_READ];
                  bcnt <= 5'h00;
                  cnt <= 5'(`ACS_SCLK_HALF_CYC - 1);
                  if (i_pwdata[`ACS_CTL_READ]) begin
                     nbits <= `ACS_RD_BITS;
                  end else if (i_pwdata[`ACS_CTL_W16]) begin
                     nbits <= `ACS_WR_BITS_L;
                     tx <= txd;
                     din <= txd[15];
                  end else begin
                     nbits <= `ACS_WR_BITS_S;
                     tx <= {txd[7:0], 8'h00};
                     din <= txd[7];
                  end
               end
            end
            H_CONV: begin
               if (tmo) begin
                  st <= H_IDLE;
               end
            end
            H_SEL: begin
               if (tmo) begin
                  st <= H_LOW;
                  cnt <= 5'(`ACS_SCLK_HALF_CYC - 1);
               end
            end
            H_LOW: begin
               // Rising edge: converter captures din, host samples dout
               if (tmo) begin
                  st <= H_HIGH;
                  sclk <= 1'b1;
                  cnt <= 5'(`ACS_SCLK_HALF_CYC - 1);
                  if (is_rd) begin
                     rx <= {rx[`ACS_RES_W-2:0], dat_lvl};
                  end
               end
            end
            H_HIGH: begin
               // Falling edge: both sides move to the next bit
               if (tmo) begin
                  sclk <= 1'b0;
                  bcnt <= bcnt + 5'h01;
                  tx <= {tx[14:0], 1'b0};
                  din <= tx[14];
                  cnt <= 5'(`ACS_SCLK_HALF_CYC - 1);
                  if (bcnt == nbits - 5'h01) begin
                     st <= H_DONE;
                     rd_wr <= 1'b0;
                  end else begin
                     st <= H_LOW;
                  end
               end
            end
            H_DONE: begin
               if (tmo) begin
                  st <= H_IDLE;
                  cs_n <= 1'b1;
                  if (is_rd) begin
                     rxd <= rx;
                  end
               end
            end
            default: begin
               st <= H_IDLE;
            end
         endcase
      end
   end

   // ******************************
   // Events and interrupt
   // ******************************
   assign ev = {otf_fall, (st == H_DONE) && tmo && !is_rd, (st == H_DONE) && tmo && is_rd, bsy_fall};

   // Write one to clear; a new event in the same cycle wins
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         stat <= '0;
         o_irq <= 1'b0;
      end else begin
         stat <= (stat & ~(wr_stat ? i_pwdata[`ACS_EV_W-1:0] : '0)) | ev;
         o_irq <= |(stat & mask);
      end
   end

   assign lnk.cs_n = cs_n;
   assign lnk.rd_wr = rd_wr;
   assign lnk.sclk = sclk;
   assign lnk.din = din;
   assign lnk.conv_start_n = cst_n;
endmodule
`default_nettype wire

// [rtl/acs_map.svh]
// Constants of the converter control link: timing, widths, codes and host register map
`ifndef ACS_MAP_SVH
`define ACS_MAP_SVH
// ********************
// Clock and timing
// ********************
`define ACS_CLK_NS 5
`define ACS_VCONV_NS 9000
`define ACS_TCONV_NS 27000
`define ACS_VCONV_CYC (`ACS_VCONV_NS / `ACS_CLK_NS)
`define ACS_TCONV_CYC (`ACS_TCONV_NS / `ACS_CLK_NS)
`define ACS_CST_LO_NS 20
`define ACS_CST_LO_CYC ((`ACS_CST_LO_NS + `ACS_CLK_NS - 1) / `ACS_CLK_NS)
`define ACS_SCLK_HALF_NS 80
`define ACS_SCLK_HALF_CYC (`ACS_SCLK_HALF_NS / `ACS_CLK_NS)
// ********************
// Widths and codes
// ********************
`define ACS_RES_W 10
`define ACS_CHAN_W 3
`define ACS_CHAN_TEMP 3'h0
`define ACS_CHAN_LAST 3'h4
`define ACS_LIMIT_SEL 3'h7
`define ACS_LIMIT_RST 8'hFF
`define ACS_RD_BITS 5'h0A
`define ACS_WR_BITS_S 5'h08
`define ACS_WR_BITS_L 5'h10
// ********************
// Host register map
// ********************
`define ACS_REG_CTRL 8'h00
`define ACS_REG_TXD 8'h04
`define ACS_REG_RXD 8'h08
`define ACS_REG_STAT 8'h0C
`define ACS_REG_MASK 8'h10
`define ACS_CTL_START 0
`define ACS_CTL_PD 1
`define ACS_CTL_READ 2
`define ACS_CTL_WRITE 3
`define ACS_CTL_W16 4
`define ACS_CTL_ENG 8
`define ACS_CTL_BUSY 9
`define ACS_CTL_OTF 10
`define ACS_EV_W 4
`endif

// [rtl/acs_pkg.sv]
// Types shared by both ends of the converter control link
package acs_pkg;
`include "acs_map.svh"
   // Channel code: 0 is the temperature sensor, 1 to 4 the analog inputs
   typedef logic [`ACS_CHAN_W-1:0] acs_chan_t;
   // Converter sequencing states
   typedef enum logic {CNV_IDLE = 1'b0, CNV_RUN = 1'b1} acs_cnv_t;
   // Host engine states, Gray coded along the transfer path except the H_DONE to H_IDLE step
   typedef enum logic [2:0] {
      H_IDLE = 3'b000,
      H_SEL = 3'b001,
      H_LOW = 3'b011,
      H_HIGH = 3'b010,
      H_DONE = 3'b110,
      H_CONV = 3'b100
   } acs_hst_t;
endpackage

// [rtl/acs_if.sv]
// Pins between the converter and the host controller
`timescale 1ns/1ps
`default_nettype none
interface acs_if;
   logic conv_start_n; // Convert start, active low
   logic busy; // Conversion in progress
   logic over_temp_flag_n; // Over-temperature, active low
   logic cs_n; // Port select, active low
   logic rd_wr; // High read, low write
   logic sclk; // Shift clock
   logic din; // Serial data into converter
   logic dout; // Serial data out of converter
   logic dout_oe; // Converter drives dout
   logic dout_line; // Resolved wire, pulled up when released
   assign dout_line = dout_oe ? dout : 1'b1;
   modport dev (
      input conv_start_n, cs_n, rd_wr, sclk, din,
      output busy, over_temp_flag_n, dout, dout_oe
   );
   modport host (
      output conv_start_n, cs_n, rd_wr, sclk, din,
      input busy, over_temp_flag_n, dout_line
   );
endinterface
`default_nettype wire

// [rtl/acs_sync.sv]
// Two-stage synchroniser with edge detection for one pin
`timescale 1ns/1ps
`default_nettype none
module acs_sync #(
   parameter logic P_INIT = 1'b0
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // Pin
   input wire logic i_async,
   // Synchronised level and edges
   output logic o_lvl,
   output logic o_rise,
   output logic o_fall
);
   logic meta; // First stage, read only by the second
   logic prev; // Previous stable level

   // Sampling chain; reset to the pin's idle level to avoid false edges
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         meta <= P_INIT;
         o_lvl <= P_INIT;
         prev <= P_INIT;
      end else begin
         meta <= i_async;
         o_lvl <= meta;
         prev <= o_lvl;
      end
   end

   assign o_rise = o_lvl & ~prev;
   assign o_fall = ~o_lvl & prev;
endmodule
`default_nettype wire

// [rtl/acs_dev.sv]
// Converter end: conversion sequencing, over-temperature flag and serial port
`timescale 1ns/1ps
`default_nettype none
`include "acs_map.svh"
module acs_dev #(
   parameter int P_VCONV_CYC = `ACS_VCONV_CYC,
   parameter int P_TCONV_CYC = `ACS_TCONV_CYC
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // Pins toward the host
   acs_if.dev lnk,
   // Converter core
   input wire logic [`ACS_RES_W-1:0] i_conv_result,
   output logic o_hold,
   output logic o_power_down,
   output acs_pkg::acs_chan_t o_chan,
   output logic [`ACS_RES_W-1:0] o_result,
   output logic o_result_valid
);
   import acs_pkg::*;

   // ******************************
   // Pin synchronisers
   // ******************************
   logic cst_lvl, cst_fall; // Convert start
   logic cs_lvl, cs_rise, cs_fall; // Port select
   logic rw_lvl, rw_rise, rw_fall; // Direction
   logic sck_rise, sck_fall; // Shift clock
   logic din_lvl; // Serial input, level only

   acs_sync #(.P_INIT(1'b1)) u_cst (
      .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_async(lnk.conv_start_n),
      .o_lvl(cst_lvl), .o_rise(), .o_fall(cst_fall)
   );
   acs_sync #(.P_INIT(1'b1)) u_cs (
      .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_async(lnk.cs_n),
      .o_lvl(cs_lvl), .o_rise(cs_rise), .o_fall(cs_fall)
   );
   acs_sync #(.P_INIT(1'b0)) u_rw (
      .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_async(lnk.rd_wr),
      .o_lvl(rw_lvl), .o_rise(rw_rise), .o_fall(rw_fall)
   );
   acs_sync #(.P_INIT(1'b0)) u_sck (
      .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_async(lnk.sclk),
      .o_lvl(), .o_rise(sck_rise), .o_fall(sck_fall)
   );
   // Data goes through the same depth as the clock, so both stay aligned
   acs_sync #(.P_INIT(1'b0)) u_din (
      .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_async(lnk.din),
      .o_lvl(din_lvl), .o_rise(), .o_fall()
   );

   // ******************************
   // Conversion sequencing
   // ******************************
   acs_cnv_t cnv_st; // Sequencer state
   logic [15:0] cnv_cnt; // Cycles left in conversion
   acs_chan_t addr; // Address register, channel to convert
   logic [7:0] limit; // Temperature limit register
   logic sel; // Port selected
   logic conv_go; // Conversion accepted this cycle
   logic conv_done; // Last cycle of a conversion
   logic busy; // Busy pin flop
   logic otf_n; // Over-temperature flop

   assign sel = ~cs_lvl;
   // Edges during a conversion are dropped; the core cannot restart mid-way
   assign conv_go = (cnv_st == CNV_IDLE) && cst_fall;
   assign conv_done = (cnv_st == CNV_RUN) && (cnv_cnt == 16'h0000);

   // State and down-counter; temperature channel takes the long budget
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         cnv_st <= CNV_IDLE;
         cnv_cnt <= 16'h0000;
      end else begin
         case (cnv_st)
            CNV_IDLE: begin
               if (conv_go) begin
                  cnv_st <= CNV_RUN;
                  if (addr == `ACS_CHAN_TEMP) begin
                     cnv_cnt <= 16'(P_TCONV_CYC - 1);
                  end else begin
                     cnv_cnt <= 16'(P_VCONV_CYC - 1);
                  end
               end
            end
            CNV_RUN: begin
               if (conv_done) begin
                  cnv_st <= CNV_IDLE;
               end else begin
                  cnv_cnt <= cnv_cnt - 16'h0001;
               end
            end
            default: begin
               cnv_st <= CNV_IDLE;
            end
         endcase
      end
   end

   // Busy pin follows the sequencer exactly
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         busy <= 1'b0;
      end else if (conv_go) begin
         busy <= 1'b1;
      end else if (conv_done) begin
         busy <= 1'b0;
      end
   end

   // Track/hold control toward the core
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_hold <= 1'b0;
      end else if (conv_go) begin
         o_hold <= 1'b1;
      end else if (conv_done) begin
         o_hold <= 1'b0;
      end
   end

   // Power-down sampled at the end; the next start wakes the core
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_power_down <= 1'b0;
      end else if (conv_go) begin
         o_power_down <= 1'b0;
      end else if (conv_done) begin
         o_power_down <= ~cst_lvl;
      end
   end

   // Channel frozen for the whole conversion, result captured at the end
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_chan <= `ACS_CHAN_TEMP;
         o_result <= '0;
         o_result_valid <= 1'b0;
      end else begin
         o_result_valid <= conv_done;
         if (conv_go) begin
            o_chan <= addr;
         end
         if (conv_done) begin
            o_result <= i_conv_result;
         end
      end
   end

   // Over-temperature: upper 8 result bits against the limit; set wins
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         otf_n <= 1'b1;
      end else if (conv_done && (o_chan == `ACS_CHAN_TEMP) &&
                   (i_conv_result[`ACS_RES_W-1 -: 8] > limit)) begin
         otf_n <= 1'b0;
      end else if (sel && rw_rise) begin
         otf_n <= 1'b1;
      end
   end

   // ******************************
   // Serial write side
   // ******************************
   logic [4:0] bcnt; // Bits received in this frame
   logic [7:0] sin; // Input shift register
   logic [7:0] next_sin; // Shift register after this bit
   logic lim_pend; // Second byte goes to the limit register
   logic wr_bit; // A write bit is captured now

   assign next_sin = {sin[6:0], din_lvl};
   // Nothing moves while deselected, so a shared bus cannot disturb us
   assign wr_bit = sel && ~rw_lvl && sck_rise;

   // Frame bit counter, restarted on select or on entry to write
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         bcnt <= 5'h00;
         sin <= 8'h00;
      end else if (cs_fall || (sel && rw_fall)) begin
         bcnt <= 5'h00;
      end else if (wr_bit) begin
         sin <= next_sin;
         if (bcnt != `ACS_WR_BITS_L) begin
            bcnt <= bcnt + 5'h01;
         end
      end
   end

   // Address and limit registers; codes 5 and 6 are ignored
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         addr <= `ACS_CHAN_TEMP;
         limit <= `ACS_LIMIT_RST;
         lim_pend <= 1'b0;
      end else if (cs_fall) begin
         lim_pend <= 1'b0;
      end else if (wr_bit && (bcnt == `ACS_WR_BITS_S - 5'h01)) begin
         if (next_sin[2:0] == `ACS_LIMIT_SEL) begin
            lim_pend <= 1'b1;
         end else if (next_sin[2:0] <= `ACS_CHAN_LAST) begin
            addr <= next_sin[2:0];
         end
      end else if (wr_bit && lim_pend && (bcnt == `ACS_WR_BITS_L - 5'h01)) begin
         limit <= next_sin;
         lim_pend <= 1'b0;
      end
   end

   // ******************************
   // Serial read side
   // ******************************
   logic [`ACS_RES_W-1:0] sout; // Output shift register
   logic dout_oe; // Output driven

   // MSB is presented when read is signalled, then one bit per falling edge
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         sout <= '0;
         dout_oe <= 1'b0;
      end else if (sel && rw_rise) begin
         sout <= o_result;
         dout_oe <= 1'b1;
      end else if (rw_fall || cs_rise) begin
         dout_oe <= 1'b0;
      end else if (sel && rw_lvl && sck_fall) begin
         sout <= {sout[`ACS_RES_W-2:0], 1'b0};
      end
   end

   assign lnk.busy = busy;
   assign lnk.over_temp_flag_n = otf_n;
   assign lnk.dout = sout[`ACS_RES_W-1];
   assign lnk.dout_oe = dout_oe;
endmodule
`default_nettype wire

// [dv/acs_checker.sv]
// Checker of the pins between the converter and the host
`timescale 1ns/1ps
`default_nettype none
module acs_checker #(
   parameter int P_TCONV_CYC = 5400
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // Link pins
   input wire logic conv_start_n,
   input wire logic busy,
   input wire logic over_temp_flag_n,
   input wire logic cs_n,
   input wire logic rd_wr,
   input wire logic sclk,
   input wire logic dout,
   input wire logic dout_oe
);
   // ********************
   // Helpers
   // ********************
   int busy_cnt; // Cycles of the running conversion
   // Counter instead of a long repetition, which the tools unroll
   always_ff @(posedge i_clk) begin
      if (i_sys_rst || !busy) begin
         busy_cnt <= 0;
      end else begin
         busy_cnt <= busy_cnt + 1;
      end
   end
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   sequence start_seen;
      $fell(conv_start_n) && !busy;
   endsequence
   sequence busy_run;
      busy [*8];
   endsequence
   // ********************
   // Properties
   // ********************
   start_busy_a: assert property (start_seen |-> ##[1:6] busy)
      else $error("busy late after start");
   busy_hold_a: assert property ($rose(busy) |-> busy_run)
      else $error("busy dropped early");
   conv_time_a: assert property (busy_cnt <= P_TCONV_CYC + 2)
      else $error("conversion too long");
   flag_set_a: assert property ($fell(over_temp_flag_n) |-> $fell(busy))
      else $error("flag fell off conversion end");
   flag_why_a: assert property ($rose(over_temp_flag_n) |-> rd_wr && !cs_n)
      else $error("flag released without read");
   flag_clr_a: assert property (!over_temp_flag_n && $rose(rd_wr) && !cs_n |-> ##[1:6] over_temp_flag_n)
      else $error("flag not released");
   oe_start_a: assert property ($rose(dout_oe) |-> !cs_n && rd_wr)
      else $error("dout driven unselected");
   oe_dir_a: assert property ($fell(rd_wr) |-> ##[0:4] !dout_oe)
      else $error("dout held after direction fall");
   oe_cs_a: assert property ($rose(cs_n) |-> ##[0:4] !dout_oe)
      else $error("dout held after deselect");
   dout_edge_a: assert property (dout_oe && $past(dout_oe) && $changed(dout) |-> !sclk)
      else $error("dout moved with shift clock high");
endmodule
`default_nettype wire

// [dv/adc_conversion_serial_control_bench.sv]
// Bench joining both ends of the converter link through APB
`timescale 1ns/1ps
`default_nettype none
`include "acs_map.svh"
module adc_conversion_serial_control_bench;
   import acs_pkg::*;
   // ********************
   // Signals and instances
   // ********************
   logic i_clk = 1'b0; // 200 MHz clock
   logic i_sys_rst = 1'b1; // Held for two cycles
   logic psel = 1'b0, pen = 1'b0, pwr = 1'b0; // APB request
   logic [7:0] padr = 8'h00; // APB address
   logic [31:0] pwd = 32'h0, prd, rd; // APB data
   logic prdy, perr, irq, err; // APB answer, interrupt
   logic [9:0] res = 10'h000; // Core result fed to the converter
   logic hold, pd; // Converter state
   acs_chan_t chan; // Converted channel
   logic [9:0] dres; // Converter result
   logic vld; // Result strobe
   int nv = 0, bl = 0, blen = 0; // Result strobes, busy run, last busy length
   int bad_count = 0, n_checks = 0, pk; // Counts
   always #2.5 i_clk = ~i_clk;
   acs_if lnk_if();
   // Counts result strobes and measures each busy period on the pin
   always @(posedge i_clk) begin
      if (vld === 1'b1) nv <= nv + 1;
      if (lnk_if.busy === 1'b1) bl <= bl + 1;
      else if (bl != 0) begin
         blen <= bl;
         bl <= 0;
      end
   end
   // Short conversions keep the run brief
   acs_dev #(.P_VCONV_CYC(20), .P_TCONV_CYC(40)) acs_dev_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
      .lnk(lnk_if.dev), .i_conv_result(res), .o_hold(hold), .o_power_down(pd), .o_chan(chan),
      .o_result(dres), .o_result_valid(vld));
   acs_host acs_host_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_psel(psel), .i_penable(pen),
      .i_pwrite(pwr), .i_paddr(padr), .i_pwdata(pwd), .o_prdata(prd), .o_pready(prdy),
      .o_pslverr(perr), .o_irq(irq), .lnk(lnk_if.host));
   acs_checker #(.P_TCONV_CYC(40)) acs_checker_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
      .conv_start_n(lnk_if.conv_start_n), .busy(lnk_if.busy), .over_temp_flag_n(lnk_if.over_temp_flag_n),
      .cs_n(lnk_if.cs_n), .rd_wr(lnk_if.rd_wr), .sclk(lnk_if.sclk), .dout(lnk_if.dout),
      .dout_oe(lnk_if.dout_oe));
   // ********************
   // Tasks
   // ********************
   task final_report;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("FAIL %0t seen %h want %h", $time, seen, exp);
      end
   endtask
   // A used-up wait counts as a mismatch and ends the run
   task lim(input int k, input int n);
      if (k >= n) begin
         bad_count++;
         final_report;
      end
   endtask
   // One APB transfer; request held until pready is seen
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      psel <= 1'b1;
      pwr <= w;
      padr <= a;
      pwd <= d;
      @(posedge i_clk);
      pen <= 1'b1;
      k = 0;
      do begin
         @(posedge i_clk);
         k++;
      end while (prdy !== 1'b1 && k < 20);
      lim(k, 20);
      rd = prd;
      err = perr;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge i_clk);
   endtask
   // Command, wait for the interrupt, check and clear status
   task op(input logic [31:0] ctl, input logic [3:0] ev);
      int k;
      apb(1'b1, `ACS_REG_CTRL, ctl);
      k = 0;
      while (irq !== 1'b1 && k < 3000) begin
         @(posedge i_clk);
         k++;
      end
      lim(k, 3000);
      apb(1'b0, `ACS_REG_STAT, 32'h0);
      chk(rd, {28'h0, ev});
      apb(1'b1, `ACS_REG_STAT, {28'h0, ev});
   endtask
   // ********************
   // Sequence
   // ********************
   initial begin
      repeat (2) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      @(posedge i_clk);
      apb(1'b0, `ACS_REG_CTRL, 32'h0);
      chk(rd, 32'h400);
      apb(1'b0, 8'h14, 32'h0);
      chk({31'h0, err}, 32'h1);
      apb(1'b1, `ACS_REG_MASK, 32'hF);
      apb(1'b1, `ACS_REG_TXD, 32'h0740);
      op(32'h18, 4'h4);
      apb(1'b1, `ACS_REG_TXD, 32'h0);
      op(32'h8, 4'h4);
      res <= 10'h104;
      // Temperature above limit: done and flag together
      op(32'h1, 4'h9);
      chk(blen, 32'h28);
      chk({22'h0, dres}, 32'h104);
      chk({31'h0, hold}, 32'h0);
      apb(1'b0, `ACS_REG_CTRL, 32'h0);
      chk(rd & 32'h400, 32'h0);
      op(32'h4, 4'h2);
      apb(1'b0, `ACS_REG_RXD, 32'h0);
      chk(rd, 32'h104);
      apb(1'b0, `ACS_REG_CTRL, 32'h0);
      chk(rd & 32'h400, 32'h400);
      // Equal to the limit does not trip the flag
      res <= 10'h103;
      op(32'h1, 4'h1);
      apb(1'b1, `ACS_REG_TXD, 32'h0202);
      op(32'h8, 4'h4);
      op(32'h1, 4'h1);
      chk(blen, 32'h14);
      chk({29'h0, chan}, 32'h2);
      op(32'h3, 4'h1);
      chk({31'h0, pd}, 32'h1);
      apb(1'b1, `ACS_REG_CTRL, 32'h0);
      op(32'h1, 4'h1);
      chk({31'h0, pd}, 32'h0);
      // Masked event stays off the interrupt line
      apb(1'b1, `ACS_REG_MASK, 32'h0);
      apb(1'b1, `ACS_REG_CTRL, 32'h1);
      apb(1'b0, `ACS_REG_MASK, 32'h0);
      chk({31'h0, hold}, 32'h1);
      pk = 0;
      do begin
         apb(1'b0, `ACS_REG_STAT, 32'h0);
         pk++;
      end while (rd[0] !== 1'b1 && pk < 200);
      lim(pk, 200);
      chk({31'h0, irq}, 32'h0);
      apb(1'b1, `ACS_REG_MASK, 32'h1);
      apb(1'b0, `ACS_REG_STAT, 32'h0);
      chk({31'h0, irq}, 32'h1);
      apb(1'b1, `ACS_REG_STAT, 32'h1);
      apb(1'b0, `ACS_REG_STAT, 32'h0);
      chk({31'h0, irq}, 32'h0);
      chk(nv, 32'h6);
      final_report;
   end
endmodule
`default_nettype wire
